//--- rtl/mbs_defs.svh
/*
 * Constants of the register-access server: function codes, exception codes,
 * frame lengths and the supported register window.
 * Assumes inclusion by bare name from each design file that needs it.
 */
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

`define MBS_FC_READ_MULTI   8'h03
`define MBS_FC_WRITE_SINGLE 8'h06
`define MBS_FC_WRITE_MULTI  8'h10
`define MBS_FC_ERR_BIT      8'h80

`define MBS_EXC_NONE        8'h00
`define MBS_EXC_BAD_FUNC    8'h01
`define MBS_EXC_BAD_REG     8'h02
`define MBS_EXC_BAD_QTY     8'h03
`define MBS_EXC_BAD_VALUE   8'h21

`define MBS_QTY_MIN         16'h0001
`define MBS_QTY_MAX         16'h0010
`define MBS_ADDR_ADJ        16'h0001
`define MBS_REG_FIRST       17'h00001
`define MBS_REG_LAST        17'h00040
`define MBS_REG_AW          6
`define MBS_VAL_LIMIT       16'h7FFF

`define MBS_LEN_FIXED       8'h06
`define MBS_LEN_MULTI_HDR   8'h07
`define MBS_LEN_ERR         8'h03
`define MBS_LEN_READ_HDR    8'h03
`define MBS_CNT_MAX         8'hFF

`endif

//--- rtl/mbs_pkg.sv
/*
 * Types shared by the register-access server.
 * Assumes mbs_defs.svh supplies the numeric constants.
 */
package mbs_pkg;
	typedef enum logic [3:0] {
		MBS_S_RECV  = 4'h1,
		MBS_S_CHECK = 4'h2,
		MBS_S_WRITE = 4'h4,
		MBS_S_RESP  = 4'h8
	} mbs_state_t;

	typedef logic [15:0] mbs_word_t;
	typedef logic [7:0]  mbs_byte_t;
endpackage : mbs_pkg

//--- rtl/mbs_reg_if.sv
/*
 * Port between the command engine and the holding-register store.
 * Assumes both ends run on the same clock.
 */
`include "mbs_defs.svh"

interface mbs_reg_if;
	import mbs_pkg::*;
	logic                     we;
	logic [`MBS_REG_AW-1:0]   waddr;
	mbs_word_t                wdata;
	logic [`MBS_REG_AW-1:0]   raddr;
	mbs_word_t                rdata;

	modport srv (output we, output waddr, output wdata, output raddr, input rdata);
	modport rf  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mbs_reg_if

//--- rtl/mbs_regstore.sv
/*
 * Holding-register store: one word per supported register, indexed from zero.
 * Assumes the engine has range-checked every address before use.
 */
`include "mbs_defs.svh"

module mbs_regstore (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Engine side
	mbs_reg_if.rf    reg_if
);
	import mbs_pkg::*;

	mbs_word_t mem [0:(1<<`MBS_REG_AW)-1];

	assign reg_if.rdata = mem[reg_if.raddr];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < (1<<`MBS_REG_AW); i++) begin
				mem[i] <= 16'h0000;
			end
		end else if (reg_if.we) begin
			mem[reg_if.waddr] <= reg_if.wdata;
		end
	end
endmodule : mbs_regstore

//--- rtl/mbs_server.sv
/*
 * Register-access command server: parses one command from a byte stream,
 * checks it, writes or reads the holding registers, and streams one reply.
 * Assumes the transport strips framing and delivers each command's bytes
 * on the same clock, marking the final byte with RX_LAST_I.
 */
`include "mbs_defs.svh"

// Notes on behaviour
// - Reply starts with the received unit identifier, unchanged, any byte value.
// - Received register address is incremented by one before any access.
// - Function 06 carries address and value; value goes into that register.
// - Successful single write replies with an exact echo of the command.
// - Failed single write replies unit id, 86, exception code.
// - Invalid register value is reported with exception code 21.
// - Unsupported register number is reported with exception code 02.
// - Function 10 writes consecutive registers from start, count, byte count, data.
// - Register count from one to sixteen is accepted.
// - Data byte count must be twice the register count.
// - Each register value travels high byte first, then low byte.
// - Successful multiple write replies unit id, 10, start as received, count.
// - Failed multiple write replies unit id, 90, exception code.
// - Read reply gives 03, byte count 2N, values in ascending order.
// - Failed multiple read replies unit id, 83, exception code.
// - Error replies set the top bit of the function code.
module mbs_server (
	// Clock and reset
	input  wire logic           CORE_CLK_I,
	input  wire logic           RST_B_I,
	// Command byte stream
	input  wire logic           RX_VALID_I,
	input  wire mbs_pkg::mbs_byte_t RX_DATA_I,
	input  wire logic           RX_LAST_I,
	output logic                RX_READY_O,
	// Reply byte stream
	output logic                TX_VALID_O,
	output mbs_pkg::mbs_byte_t  TX_DATA_O,
	output logic                TX_LAST_O,
	input  wire logic           TX_READY_I
);
	import mbs_pkg::*;

	function automatic logic val_bad(input mbs_word_t w);
		return w > `MBS_VAL_LIMIT;
	endfunction : val_bad

	function automatic logic [`MBS_REG_AW-1:0] reg_index(input mbs_word_t base, input logic [4:0] off);
		mbs_word_t a;
		a = base + {11'h000, off} - 16'(`MBS_REG_FIRST);
		return a[`MBS_REG_AW-1:0];
	endfunction : reg_index

	mbs_reg_if reg_if ();

	mbs_regstore u_store (
		.clk_i   (CORE_CLK_I),
		.rst_b_i (RST_B_I),
		.reg_if  (reg_if)
	);

	mbs_state_t state;
	mbs_byte_t  unit_id;
	mbs_byte_t  func;
	mbs_byte_t  addr_hi;
	mbs_byte_t  addr_lo;
	mbs_byte_t  qty_hi;
	mbs_byte_t  qty_lo;
	mbs_byte_t  byte_cnt;
	mbs_byte_t  rx_cnt;
	mbs_byte_t  exc;
	mbs_byte_t  tx_idx;
	logic [4:0] w_idx;
	mbs_word_t  wbuf [0:15];
	logic       tx_valid;
	mbs_byte_t  tx_data;
	logic       tx_last;

	// Decode of the captured command
	wire mbs_word_t start     = {addr_hi, addr_lo} + `MBS_ADDR_ADJ;
	wire mbs_word_t qty       = {qty_hi, qty_lo};
	wire logic      is_read   = func == `MBS_FC_READ_MULTI;
	wire logic      is_single = func == `MBS_FC_WRITE_SINGLE;
	wire logic      is_multi  = func == `MBS_FC_WRITE_MULTI;
	wire mbs_word_t eff_qty   = is_single ? `MBS_QTY_MIN : qty;
	wire logic [16:0] last_reg = {1'b0, start} + {1'b0, eff_qty} - `MBS_REG_FIRST;
	wire logic      qty_ok    = is_single || (qty >= `MBS_QTY_MIN && qty <= `MBS_QTY_MAX);
	wire logic      len_ok    = is_multi ? (rx_cnt == `MBS_LEN_MULTI_HDR + byte_cnt &&
	                                        {8'h00, byte_cnt} == {qty[14:0], 1'b0})
	                                     : rx_cnt == `MBS_LEN_FIXED;
	wire logic      range_ok  = {1'b0, start} >= `MBS_REG_FIRST && last_reg <= `MBS_REG_LAST;
	logic           value_bad;
	always_comb begin
		value_bad = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (!is_read && i < eff_qty && val_bad(wbuf[i])) begin
				value_bad = 1'b1;
			end
		end
	end
	wire mbs_byte_t next_exc = !(is_read || is_single || is_multi) ? `MBS_EXC_BAD_FUNC :
	                           (!len_ok || !qty_ok)                ? `MBS_EXC_BAD_QTY  :
	                           !range_ok                           ? `MBS_EXC_BAD_REG  :
	                           value_bad                           ? `MBS_EXC_BAD_VALUE :
	                                                                 `MBS_EXC_NONE;

	// Receive data byte placement, high byte at even offset
	wire mbs_byte_t data_off = rx_cnt - `MBS_LEN_MULTI_HDR;
	wire logic      data_in  = is_multi && rx_cnt >= `MBS_LEN_MULTI_HDR && data_off < 8'h20;

	// Register port
	assign reg_if.we    = state == MBS_S_WRITE;
	assign reg_if.waddr = reg_index(start, w_idx);
	assign reg_if.wdata = wbuf[w_idx[3:0]];
	wire mbs_byte_t rd_off = tx_idx - `MBS_LEN_READ_HDR;
	assign reg_if.raddr = reg_index(start, rd_off[5:1]);

	// Reply length and byte at index tx_idx
	wire mbs_byte_t tx_len = exc != `MBS_EXC_NONE ? `MBS_LEN_ERR :
	                         is_read ? `MBS_LEN_READ_HDR + {qty_lo[6:0], 1'b0} : `MBS_LEN_FIXED;
	wire mbs_byte_t fc_out = exc != `MBS_EXC_NONE ? (func | `MBS_FC_ERR_BIT) : func;
	mbs_byte_t tx_byte;
	always_comb begin
		unique case (tx_idx)
			8'h00: tx_byte = unit_id;
			8'h01: tx_byte = fc_out;
			8'h02: tx_byte = exc != `MBS_EXC_NONE ? exc : (is_read ? {qty_lo[6:0], 1'b0} : addr_hi);
			8'h03: tx_byte = addr_lo;
			8'h04: tx_byte = qty_hi;
			8'h05: tx_byte = qty_lo;
			default: tx_byte = 8'h00;
		endcase
		if (is_read && exc == `MBS_EXC_NONE && tx_idx >= `MBS_LEN_READ_HDR) begin
			tx_byte = rd_off[0] ? reg_if.rdata[7:0] : reg_if.rdata[15:8];
		end
	end

	wire logic tx_take = !tx_valid || TX_READY_I;

	// Capture of command bytes; high-then-low pairing into the word buffer
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			unit_id  <= 8'h00;
			func     <= 8'h00;
			addr_hi  <= 8'h00;
			addr_lo  <= 8'h00;
			qty_hi   <= 8'h00;
			qty_lo   <= 8'h00;
			byte_cnt <= 8'h00;
			for (int i = 0; i < 16; i++) begin
				wbuf[i] <= 16'h0000;
			end
		end else if (state == MBS_S_RECV && RX_VALID_I) begin
			unique case (rx_cnt)
				8'h00: unit_id <= RX_DATA_I;
				8'h01: func    <= RX_DATA_I;
				8'h02: addr_hi <= RX_DATA_I;
				8'h03: addr_lo <= RX_DATA_I;
				8'h04: qty_hi  <= RX_DATA_I;
				8'h05: qty_lo  <= RX_DATA_I;
				8'h06: byte_cnt <= RX_DATA_I;
				default: ;
			endcase
			if (is_single && rx_cnt == 8'h04) begin
				wbuf[0][15:8] <= RX_DATA_I;
			end
			if (is_single && rx_cnt == 8'h05) begin
				wbuf[0][7:0] <= RX_DATA_I;
			end
			if (data_in && !data_off[0]) begin
				wbuf[data_off[4:1]][15:8] <= RX_DATA_I;
			end
			if (data_in && data_off[0]) begin
				wbuf[data_off[4:1]][7:0] <= RX_DATA_I;
			end
		end
	end

	// Sequencing: receive, check, write, reply
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state    <= MBS_S_RECV;
			rx_cnt   <= 8'h00;
			exc      <= 8'h00;
			w_idx    <= 5'h00;
			tx_idx   <= 8'h00;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
		end else begin
			unique case (state)
				MBS_S_RECV: begin
					if (RX_VALID_I) begin
						rx_cnt <= rx_cnt == `MBS_CNT_MAX ? rx_cnt : rx_cnt + 8'h01;
						if (RX_LAST_I) begin
							state <= MBS_S_CHECK;
						end
					end
				end
				MBS_S_CHECK: begin
					exc    <= next_exc;
					w_idx  <= 5'h00;
					tx_idx <= 8'h00;
					// Nothing is written unless every value passes, so a failed write leaves no trace
					state  <= (next_exc == `MBS_EXC_NONE && !is_read) ? MBS_S_WRITE : MBS_S_RESP;
				end
				MBS_S_WRITE: begin
					w_idx <= w_idx + 5'h01;
					if ({11'h000, w_idx} == eff_qty - `MBS_QTY_MIN) begin
						state <= MBS_S_RESP;
					end
				end
				MBS_S_RESP: begin
					if (tx_take) begin
						if (tx_idx < tx_len) begin
							tx_valid <= 1'b1;
							tx_data  <= tx_byte;
							tx_last  <= tx_idx == tx_len - 8'h01;
							tx_idx   <= tx_idx + 8'h01;
						end else begin
							tx_valid <= 1'b0;
							tx_last  <= 1'b0;
							rx_cnt   <= 8'h00;
							state    <= MBS_S_RECV;
						end
					end
				end
			endcase
		end
	end

	// Command input is held off while a command is being served
	assign RX_READY_O = state[0];
	assign TX_VALID_O = tx_valid;
	assign TX_DATA_O  = tx_data;
	assign TX_LAST_O  = tx_last;
endmodule : mbs_server

//--- bench/mbs_server_assertions.sv
/* Port checker for mbs_server.
   Assumes one clock domain and binding to every mbs_server. */
module mbs_server_assertions
	import mbs_pkg::*;
(
	input wire logic      CORE_CLK_I,
	input wire logic      RST_B_I,
	input wire logic      RX_VALID_I,
	input wire mbs_byte_t RX_DATA_I,
	input wire logic      RX_LAST_I,
	input wire logic      RX_READY_O,
	input wire logic      TX_VALID_O,
	input wire mbs_byte_t TX_DATA_O,
	input wire logic      TX_LAST_O,
	input wire logic      TX_READY_I
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);
	logic [7:0] rx_idx, tx_idx;
	mbs_byte_t  unit, func, qlo;
	logic       err;
	wire        rx_take = RX_VALID_I && RX_READY_O;
	wire        tx_take = TX_VALID_O && TX_READY_I;
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			{rx_idx, tx_idx, unit, func, qlo, err} <= '0;
		end else begin
			if (rx_take) rx_idx <= RX_LAST_I ? 8'h00 : rx_idx + 8'h01;
			if (rx_take && rx_idx == 8'h00) unit <= RX_DATA_I;
			if (rx_take && rx_idx == 8'h01) func <= RX_DATA_I;
			if (rx_take && rx_idx == 8'h05) qlo <= RX_DATA_I;
			if (tx_take) tx_idx <= TX_LAST_O ? 8'h00 : tx_idx + 8'h01;
			if (tx_take && tx_idx == 8'h01) err <= TX_DATA_O[7];
		end
	end
	a_unit_echo: assert property (TX_VALID_O && tx_idx == 8'h00 |-> TX_DATA_O == unit)
		else $error("reply unit differs from command");
	a_func_echo: assert property (TX_VALID_O && tx_idx == 8'h01 && !TX_DATA_O[7] |-> TX_DATA_O == func)
		else $error("normal reply function differs");
	a_err_func: assert property (TX_VALID_O && tx_idx == 8'h01 && TX_DATA_O[7] |-> TX_DATA_O == (func | 8'h80))
		else $error("error function code wrong");
	a_err_short: assert property (TX_VALID_O && tx_idx == 8'h02 && err |-> TX_LAST_O)
		else $error("error reply not three bytes");
	a_read_count: assert property (TX_VALID_O && tx_idx == 8'h02 && !err && func == 8'h03
		|-> TX_DATA_O == {qlo[6:0], 1'b0})
		else $error("read byte count wrong");
	a_busy_after: assert property (rx_take && RX_LAST_I |=> !RX_READY_O)
		else $error("command taken while busy");
	a_quiet_rx: assert property (RX_READY_O |-> !TX_VALID_O)
		else $error("reply while receiving");
	a_reply_due: assert property (rx_take && RX_LAST_I |-> ##[3:40] TX_VALID_O)
		else $error("no reply");
	a_tx_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
		else $error("reply byte dropped");
	a_free_after: assert property (tx_take && TX_LAST_O |=> RX_READY_O)
		else $error("not ready after reply");
endmodule : mbs_server_assertions

bind mbs_server mbs_server_assertions chk_u (.CORE_CLK_I, .RST_B_I, .RX_VALID_I, .RX_DATA_I, .RX_LAST_I,
	.RX_READY_O, .TX_VALID_O, .TX_DATA_O, .TX_LAST_O, .TX_READY_I);

//--- bench/mbs_master_model.sv
/* Network master model: sends whole command frames, collects one reply.
   Assumes a ready-valid command port; each byte stands until ready is seen; slow drops reply ready every other cycle. */
module mbs_master_model
	import mbs_pkg::*;
(
	input wire logic      clk_i,
	// Command stream
	output logic          rx_valid_o,
	output mbs_byte_t     rx_data_o,
	output logic          rx_last_o,
	input wire logic      rx_ready_i,
	// Reply stream
	input wire logic      tx_valid_i,
	input wire mbs_byte_t tx_data_i,
	input wire logic      tx_last_i,
	output logic          tx_ready_o
);
	timeunit 1ns;
	timeprecision 100ps;
	mbs_byte_t rsp[$];
	logic      done = 1'b0;
	logic      slow = 1'b0;
	initial begin
		{rx_valid_o, rx_data_o, rx_last_o} = '0;
		tx_ready_o = 1'b1;
	end
	always @(posedge clk_i) begin
		tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
		if (tx_valid_i && tx_ready_o) rsp.push_back(tx_data_i);
		if (tx_valid_i && tx_ready_o && tx_last_i) done <= 1'b1;
	end
	// Frames carry high byte first and byte count 2N as given by the caller
	task send(input mbs_byte_t c[$]);
		rsp.delete();
		done = 1'b0;
		for (int i = 0; i < c.size(); i++) begin
			@(posedge clk_i);
			while (rx_valid_o && !rx_ready_i) @(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= c[i];
			rx_last_o <= (i == c.size() - 1);
		end
		@(posedge clk_i);
		while (!rx_ready_i) @(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= ~rx_data_o;
		rx_last_o <= 1'b0;
	endtask : send
endmodule : mbs_master_model

//--- bench/mbs_server_tb.sv
/* Self-checking bench for mbs_server.
   Assumes the master model drives both streams and registers reset to 0000. */
module mbs_server_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import mbs_pkg::*;
	logic      clk = 1'b0;
	logic      rst_b = 1'b0;
	logic      rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	mbs_byte_t rx_data, tx_data;
	int        mismatches = 0;
	int        checks_done = 0;
	int        cyc = 0;
	always #2.5 clk = ~clk;
	mbs_server dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
		.RX_LAST_I(rx_last), .RX_READY_O(rx_ready), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
		.TX_LAST_O(tx_last), .TX_READY_I(tx_ready));
	mbs_master_model master_u (.clk_i(clk), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last),
		.rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_ready_o(tx_ready));
	task check(input mbs_byte_t seen, input mbs_byte_t exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task xact(input mbs_byte_t c[$], input mbs_byte_t e[$]);
		int n;
		n = 0;
		master_u.send(c);
		while (!master_u.done && n < 300) begin
			@(posedge clk);
			n++;
		end
		check(mbs_byte_t'(master_u.rsp.size()), mbs_byte_t'(e.size()));
		foreach (e[i]) check(master_u.rsp[i], e[i]);
	endtask : xact
	task t_reset;
		check({7'h00, rx_ready}, 8'h01);
		check({7'h00, tx_valid}, 8'h00);
		check(tx_data, 8'h00);
	endtask : t_reset
	task t_single;
		xact('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h03}, '{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h03});
		xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h03});
	endtask : t_single
	task t_multi;
		xact('{8'hAB, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h04, 8'h08, 8'h17, 8'h70, 8'h17, 8'h70, 8'h01, 8'h09,
			8'h00, 8'h00}, '{8'hAB, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h04});
		xact('{8'h02, 8'h03, 8'h00, 8'h1F, 8'h00, 8'h04}, '{8'h02, 8'h03, 8'h08, 8'h17, 8'h70, 8'h17, 8'h70,
			8'h01, 8'h09, 8'h00, 8'h00});
	endtask : t_multi
	task t_bad_value;
		xact('{8'hFF, 8'h06, 8'h00, 8'h00, 8'h80, 8'h00}, '{8'hFF, 8'h86, 8'h21});
		xact('{8'hFF, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'hFF, 8'h03, 8'h02, 8'h00, 8'h03});
	endtask : t_bad_value
	task t_limits;
		mbs_byte_t e[$];
		e = '{8'h00, 8'h03, 8'h20};
		repeat (32) e.push_back(8'h00);
		master_u.slow = 1'b1;
		xact('{8'h00, 8'h03, 8'h00, 8'h30, 8'h00, 8'h10}, e);
		master_u.slow = 1'b0;
		xact('{8'h02, 8'h03, 8'h00, 8'h40, 8'h00, 8'h01}, '{8'h02, 8'h83, 8'h02});
		xact('{8'h01, 8'h10, 8'h00, 8'h3F, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02},
			'{8'h01, 8'h90, 8'h02});
		xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11}, '{8'h01, 8'h83, 8'h03});
		xact('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01, 8'h00},
			'{8'h01, 8'h90, 8'h03});
		xact('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'hFF, 8'hFF}, '{8'h01, 8'h90, 8'h21});
		xact('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h01});
	endtask : t_limits
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	// Whole run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_single();
		t_multi();
		t_bad_value();
		t_limits();
		final_report();
	end
endmodule : mbs_server_tb
